// >>> shared/pbo_pkg.sv
// Package with pin positions and fuse defaults for the port B override logic.
package pbo_pkg;

  // ---------------------------------------------------------------------------
  // Pin positions within the port
  // ---------------------------------------------------------------------------
  localparam int unsigned PIN_SER_DATA  = 0;
  localparam int unsigned PIN_SER_DOUT  = 1;
  localparam int unsigned PIN_SER_CLK   = 2;
  localparam int unsigned PIN_CMP_B     = 3;
  localparam int unsigned PIN_OSC_IN    = 4;
  localparam int unsigned PIN_OSC_OUT   = 5;
  localparam int unsigned PIN_EXT_IRQ   = 6;
  localparam int unsigned PIN_RESET     = 7;
  localparam int unsigned PORT_WIDTH    = 8;

  // ---------------------------------------------------------------------------
  // Fuse-derived configuration values held until the first capture
  // ---------------------------------------------------------------------------
  localparam logic RST_RESET_PIN_SELECT    = 1'h1;
  localparam logic RST_PIN4_GPIO_ALLOWED   = 1'h0;
  localparam logic RST_PIN5_GPIO_ALLOWED   = 1'h0;
  localparam logic RST_EXTERNAL_CLOCK_SEL  = 1'h0;
  localparam logic RST_CAPTURE_DONE        = 1'h0;

endpackage

// >>> shared/pbo_cfg_if.sv
// Interface carrying the captured clock and reset fuse configuration.
`timescale 1ns/1ps
interface pbo_cfg_if;
  logic reset_pin_select;
  logic pin4_gpio_allowed;
  logic pin5_gpio_allowed;
  logic external_clock_selected;
  logic capture_done;

  modport src (
    output reset_pin_select,
    output pin4_gpio_allowed,
    output pin5_gpio_allowed,
    output external_clock_selected,
    output capture_done
  );

  modport snk (
    input reset_pin_select,
    input pin4_gpio_allowed,
    input pin5_gpio_allowed,
    input external_clock_selected,
    input capture_done
  );
endinterface

// >>> design/pbo_fuse_latch.sv
// Captures the static fuse configuration once after reset release.
`timescale 1ns/1ps
module pbo_fuse_latch (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Fuse levels
  input  wire logic reset_pin_select_in,
  input  wire logic pin4_gpio_allowed_in,
  input  wire logic pin5_gpio_allowed_in,
  input  wire logic external_clock_selected_in,
  // Captured configuration
  pbo_cfg_if.src    cfg
);

  logic rst_sel_q, rst_sel_d;
  logic gpio4_q, gpio4_d;
  logic gpio5_q, gpio5_d;
  logic ext_clk_q, ext_clk_d;
  logic done_q, done_d;

  // ---------------------------------------------------------------------------
  // Capture on the first edge after reset release, then hold.
  // ---------------------------------------------------------------------------
  always_comb begin
    rst_sel_d = rst_sel_q;
    gpio4_d   = gpio4_q;
    gpio5_d   = gpio5_q;
    ext_clk_d = ext_clk_q;
    done_d    = 1'h1;
    if (!done_q) begin
      rst_sel_d = reset_pin_select_in;
      gpio4_d   = pin4_gpio_allowed_in;
      gpio5_d   = pin5_gpio_allowed_in;
      ext_clk_d = external_clock_selected_in;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sel_q <= pbo_pkg::RST_RESET_PIN_SELECT;
      gpio4_q   <= pbo_pkg::RST_PIN4_GPIO_ALLOWED;
      gpio5_q   <= pbo_pkg::RST_PIN5_GPIO_ALLOWED;
      ext_clk_q <= pbo_pkg::RST_EXTERNAL_CLOCK_SEL;
      done_q    <= pbo_pkg::RST_CAPTURE_DONE;
    end else begin
      rst_sel_q <= rst_sel_d;
      gpio4_q   <= gpio4_d;
      gpio5_q   <= gpio5_d;
      ext_clk_q <= ext_clk_d;
      done_q    <= done_d;
    end
  end

  assign cfg.reset_pin_select        = rst_sel_q;
  assign cfg.pin4_gpio_allowed       = gpio4_q;
  assign cfg.pin5_gpio_allowed       = gpio5_q;
  assign cfg.external_clock_selected = ext_clk_q;
  assign cfg.capture_done            = done_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_fuse_hold_stable: assert property (@(posedge clk) disable iff (!rst_n)
    $past(done_q) |-> $stable(rst_sel_q) && $stable(gpio4_q) && $stable(gpio5_q) && $stable(ext_clk_q))
    else $error("Captured fuse value changed after capture.");

endmodule

// >>> design/pbo_top.sv
// Alternate function override logic for the eight pins of port B.
`timescale 1ns/1ps
// Summary of operation
// - Two-wire pin 0 pulls low if dir set and port bit or shift bit zero.
// - Two-wire mode turns pull-ups off and takes direction of pins 0 and 2.
// - Two-wire pin 2 pulls low if dir set and hold active or port bit zero.
// - Pin 0 drives inverted compare A when enabled and not two-wire output.
// - Pin 2 drives inverted compare B unless two-wire with direction set.
// - Pin 1 value: serial output in three-wire, else enabled compare A.
// - Pin 3 drives compare B; input enable needs group A and compare B off.
// - Pins 0 to 2 mask pin change when serial or compare uses them.
// - Digital input stays on in sleep for unmasked enabled pin change.
// - Reset use of pin 7 forces pull-up on and input; masks pin change.
// - Pin 6 input on for external irq, or group B without timer clock.
// - Oscillator claim of pins 4 and 5 forces pull-up off and input.
// - Pin 4 input forced on when external clock is selected.
// - Group B change irq needs global, group enable, and no mask.
// - External irq zero needs global flag and its mask flag.
// - Group A change irq needs global, group enable, and no mask.
module pbo_top (
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RSTN,
  // Serial unit
  input  wire logic       SERIAL_TWO_WIRE_MODE,
  input  wire logic       SERIAL_THREE_WIRE_MODE,
  input  wire logic       CLOCK_STRETCH_HOLD,
  input  wire logic       SHIFT_OUT_BIT,
  input  wire logic       SERIAL_DATA_OUT,
  input  wire logic       START_DETECT_IRQ_EN,
  // Timer compare outputs
  input  wire logic       COMPARE_A_OUT_EN,
  input  wire logic       COMPARE_B_OUT_EN,
  input  wire logic       COMPARE_A_WAVE,
  input  wire logic       COMPARE_B_WAVE,
  input  wire logic       COMPARE_A_WAVE_N,
  input  wire logic       COMPARE_B_WAVE_N,
  input  wire logic       TIMER0_EXT_CLOCK_SELECTED,
  // Port registers
  input  wire logic [7:0] PORT_OUT,
  input  wire logic [7:0] PORT_DIR,
  // Interrupt enables
  input  wire logic       GLOBAL_IRQ_EN,
  input  wire logic       GROUP_A_CHANGE_IRQ_EN,
  input  wire logic       GROUP_B_CHANGE_IRQ_EN,
  input  wire logic       EXTERNAL_IRQ_ZERO_EN,
  // Fuse configuration
  input  wire logic       RESET_PIN_SELECT,
  input  wire logic       PIN4_GPIO_ALLOWED,
  input  wire logic       PIN5_GPIO_ALLOWED,
  input  wire logic       EXTERNAL_CLOCK_SELECTED,
  // Override signals toward the port datapath
  output logic      [7:0] PULLUP_OVERRIDE_ENABLE,
  output logic      [7:0] PULLUP_OVERRIDE_VALUE,
  output logic      [7:0] DIRECTION_OVERRIDE_ENABLE,
  output logic      [7:0] DIRECTION_OVERRIDE_VALUE,
  output logic      [7:0] PORT_VALUE_OVERRIDE_ENABLE,
  output logic      [7:0] PORT_VALUE_OVERRIDE_VALUE,
  output logic      [7:0] INPUT_ENABLE_OVERRIDE_ENABLE,
  output logic      [7:0] INPUT_ENABLE_OVERRIDE_VALUE,
  // Interrupt qualifiers
  output logic      [7:0] PIN_CHANGE_ACTIVE,
  output logic            EXTERNAL_IRQ_ZERO_ACTIVE
);

  pbo_cfg_if cfg ();

  logic       two_wire;
  logic       three_wire;
  logic       grp_a_en;
  logic       grp_b_en;
  logic       irq0_en;
  logic       rst_sel;
  logic       gpio4;
  logic       gpio5;
  logic       ext_clk;
  logic [7:0] mask;

  // ---------------------------------------------------------------------------
  // Fuse capture
  // ---------------------------------------------------------------------------
  pbo_fuse_latch u_fuse (
    .clk                        (CORE_CLK),
    .rst_n                      (RSTN),
    .reset_pin_select_in        (RESET_PIN_SELECT),
    .pin4_gpio_allowed_in       (PIN4_GPIO_ALLOWED),
    .pin5_gpio_allowed_in       (PIN5_GPIO_ALLOWED),
    .external_clock_selected_in (EXTERNAL_CLOCK_SELECTED),
    .cfg                        (cfg)
  );

  assign two_wire   = SERIAL_TWO_WIRE_MODE;
  assign three_wire = SERIAL_THREE_WIRE_MODE;
  assign rst_sel    = cfg.reset_pin_select;
  assign gpio4      = cfg.pin4_gpio_allowed;
  assign gpio5      = cfg.pin5_gpio_allowed;
  assign ext_clk    = cfg.external_clock_selected;

  // ---------------------------------------------------------------------------
  // Interrupt qualification
  // ---------------------------------------------------------------------------
  // group A qualify
  assign grp_a_en = GLOBAL_IRQ_EN & GROUP_A_CHANGE_IRQ_EN;
  assign grp_b_en = GLOBAL_IRQ_EN & GROUP_B_CHANGE_IRQ_EN;
  assign irq0_en  = GLOBAL_IRQ_EN & EXTERNAL_IRQ_ZERO_EN;

  always_comb begin
    mask    = 8'h00;
    mask[0] = two_wire | three_wire | COMPARE_A_OUT_EN;
    mask[1] = three_wire | COMPARE_A_OUT_EN;
    mask[2] = two_wire | three_wire | COMPARE_B_OUT_EN;
    mask[3] = COMPARE_B_OUT_EN;
    mask[4] = ~gpio4;
    mask[5] = ~gpio5;
    mask[6] = irq0_en | TIMER0_EXT_CLOCK_SELECTED;
    mask[7] = rst_sel;
  end

  always_comb begin
    PIN_CHANGE_ACTIVE[3:0]   = {4{grp_a_en}} & ~mask[3:0];
    PIN_CHANGE_ACTIVE[7:4]   = {4{grp_b_en}} & ~mask[7:4];
    EXTERNAL_IRQ_ZERO_ACTIVE = irq0_en;
  end

  // ---------------------------------------------------------------------------
  // Pull-up and direction overrides
  // ---------------------------------------------------------------------------
  // combinational override path
  always_comb begin
    PULLUP_OVERRIDE_ENABLE    = 8'h00;
    PULLUP_OVERRIDE_VALUE     = 8'h00;
    DIRECTION_OVERRIDE_ENABLE = 8'h00;
    DIRECTION_OVERRIDE_VALUE  = 8'h00;
    PULLUP_OVERRIDE_ENABLE[0]    = two_wire;
    PULLUP_OVERRIDE_ENABLE[2]    = two_wire;
    DIRECTION_OVERRIDE_ENABLE[0] = two_wire;
    DIRECTION_OVERRIDE_ENABLE[2] = two_wire;
    DIRECTION_OVERRIDE_VALUE[0]  = (~SHIFT_OUT_BIT | ~PORT_OUT[0]) & PORT_DIR[0];
    DIRECTION_OVERRIDE_VALUE[2]  = (CLOCK_STRETCH_HOLD | ~PORT_OUT[2]) & PORT_DIR[2];
    PULLUP_OVERRIDE_ENABLE[4]    = ~gpio4;
    PULLUP_OVERRIDE_ENABLE[5]    = ~gpio5;
    DIRECTION_OVERRIDE_ENABLE[4] = ~gpio4;
    DIRECTION_OVERRIDE_ENABLE[5] = ~gpio5;
    PULLUP_OVERRIDE_ENABLE[7]    = rst_sel;
    PULLUP_OVERRIDE_VALUE[7]     = 1'h1;
    DIRECTION_OVERRIDE_ENABLE[7] = rst_sel;
  end

  // ---------------------------------------------------------------------------
  // Output value overrides
  // ---------------------------------------------------------------------------
  always_comb begin
    PORT_VALUE_OVERRIDE_ENABLE = 8'h00;
    PORT_VALUE_OVERRIDE_VALUE  = 8'h00;
    // inverted compare A on pin 0
    PORT_VALUE_OVERRIDE_ENABLE[0] = (two_wire & PORT_DIR[0]) | COMPARE_A_OUT_EN;
    PORT_VALUE_OVERRIDE_VALUE[0]  = ~(two_wire & PORT_DIR[0]) & COMPARE_A_OUT_EN & COMPARE_A_WAVE_N;
    PORT_VALUE_OVERRIDE_ENABLE[1] = three_wire | COMPARE_A_OUT_EN;
    PORT_VALUE_OVERRIDE_VALUE[1]  = (three_wire & SERIAL_DATA_OUT)
                                  | (~three_wire & COMPARE_A_OUT_EN & COMPARE_A_WAVE);
    // inverted compare B on pin 2
    PORT_VALUE_OVERRIDE_ENABLE[2] = (two_wire & PORT_DIR[2]) | COMPARE_B_OUT_EN;
    PORT_VALUE_OVERRIDE_VALUE[2]  = ~(two_wire & PORT_DIR[2]) & COMPARE_B_WAVE_N;
    PORT_VALUE_OVERRIDE_ENABLE[3] = COMPARE_B_OUT_EN;
    PORT_VALUE_OVERRIDE_VALUE[3]  = COMPARE_B_WAVE;
  end

  // ---------------------------------------------------------------------------
  // Digital input enable overrides
  // ---------------------------------------------------------------------------
  always_comb begin
    INPUT_ENABLE_OVERRIDE_ENABLE = 8'h00;
    INPUT_ENABLE_OVERRIDE_VALUE  = 8'hff;
    // keep input alive for unmasked pin change
    INPUT_ENABLE_OVERRIDE_ENABLE[0] = (~mask[0] & grp_a_en) | START_DETECT_IRQ_EN;
    INPUT_ENABLE_OVERRIDE_ENABLE[1] = ~mask[1] & grp_a_en;
    INPUT_ENABLE_OVERRIDE_ENABLE[2] = (~mask[2] & grp_a_en) | START_DETECT_IRQ_EN;
    INPUT_ENABLE_OVERRIDE_ENABLE[3] = grp_a_en & ~COMPARE_B_OUT_EN;
    INPUT_ENABLE_OVERRIDE_ENABLE[4] = grp_b_en | ~gpio4 | ext_clk;
    INPUT_ENABLE_OVERRIDE_VALUE[4]  = (grp_b_en & gpio4) | ext_clk;
    INPUT_ENABLE_OVERRIDE_ENABLE[5] = grp_b_en | ~gpio5;
    INPUT_ENABLE_OVERRIDE_VALUE[5]  = grp_b_en & gpio5;
    INPUT_ENABLE_OVERRIDE_ENABLE[6] = (~TIMER0_EXT_CLOCK_SELECTED & grp_b_en) | irq0_en;
    INPUT_ENABLE_OVERRIDE_ENABLE[7] = grp_b_en | rst_sel;
    INPUT_ENABLE_OVERRIDE_VALUE[7]  = grp_b_en & ~rst_sel;
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_two_wire_out0;
    two_wire && PORT_DIR[0];
  endsequence

  sequence s_data_low;
    !SHIFT_OUT_BIT || !PORT_OUT[0];
  endsequence

  a_sda_pull_low: assert property (s_two_wire_out0 ##0 s_data_low |->
    DIRECTION_OVERRIDE_ENABLE[0] && DIRECTION_OVERRIDE_VALUE[0]
    && PORT_VALUE_OVERRIDE_ENABLE[0] && !PORT_VALUE_OVERRIDE_VALUE[0])
    else $error("Data line not pulled low.");

  a_two_wire_pullup: assert property (two_wire |->
    PULLUP_OVERRIDE_ENABLE[0] && PULLUP_OVERRIDE_ENABLE[2] && !PULLUP_OVERRIDE_VALUE[2])
    else $error("Pull-up not disabled in two-wire mode.");

  a_scl_release: assert property (two_wire && PORT_OUT[2] && !CLOCK_STRETCH_HOLD |->
    !DIRECTION_OVERRIDE_VALUE[2])
    else $error("Clock line held without cause.");

  a_cmpa_pin0: assert property (COMPARE_A_OUT_EN && !two_wire |->
    PORT_VALUE_OVERRIDE_VALUE[0] == COMPARE_A_WAVE_N)
    else $error("Pin 0 not carrying inverted compare A.");

  a_dout_pin1: assert property (three_wire |->
    PORT_VALUE_OVERRIDE_ENABLE[1] && PORT_VALUE_OVERRIDE_VALUE[1] == SERIAL_DATA_OUT)
    else $error("Pin 1 not carrying serial output.");

  a_cmpb_pin3: assert property (PORT_VALUE_OVERRIDE_ENABLE[3] == COMPARE_B_OUT_EN
    && (!COMPARE_B_OUT_EN || PORT_VALUE_OVERRIDE_VALUE[3] == COMPARE_B_WAVE))
    else $error("Pin 3 compare B override wrong.");

  a_reset_pin_mask: assert property (rst_sel |->
    !PIN_CHANGE_ACTIVE[7] && !INPUT_ENABLE_OVERRIDE_VALUE[7] && PULLUP_OVERRIDE_ENABLE[7])
    else $error("Reset pin not masked.");

  a_osc_claim: assert property (!gpio5 |->
    DIRECTION_OVERRIDE_ENABLE[5] && !DIRECTION_OVERRIDE_VALUE[5] && !PIN_CHANGE_ACTIVE[5])
    else $error("Oscillator pin not claimed.");

  a_ext_clk_input: assert property (ext_clk |->
    INPUT_ENABLE_OVERRIDE_ENABLE[4] && INPUT_ENABLE_OVERRIDE_VALUE[4])
    else $error("External clock input not enabled.");

  a_irq0_qualify: assert property (EXTERNAL_IRQ_ZERO_ACTIVE == (GLOBAL_IRQ_EN && EXTERNAL_IRQ_ZERO_EN))
    else $error("External irq qualification wrong.");

  a_group_a_mask: assert property (PIN_CHANGE_ACTIVE[1] ==
    (GLOBAL_IRQ_EN && GROUP_A_CHANGE_IRQ_EN && !three_wire && !COMPARE_A_OUT_EN))
    else $error("Group A pin change qualification wrong.");

  a_same_cycle: assert property ($rose(COMPARE_B_OUT_EN) |-> PORT_VALUE_OVERRIDE_ENABLE[3]
    && !INPUT_ENABLE_OVERRIDE_ENABLE[3])
    else $error("Override did not follow its input in the same cycle.");

endmodule

// >>> verification/pbo_pin_model.sv
// Pad model of the port B pins with external pull-ups.
`timescale 1ns/1ps
module pbo_pin_model (
  // Override signals
  input  wire logic [7:0] direction_override_enable,
  input  wire logic [7:0] direction_override_value,
  input  wire logic [7:0] port_value_override_enable,
  input  wire logic [7:0] port_value_override_value,
  // Port registers
  input  wire logic [7:0] pdir,
  input  wire logic [7:0] pout,
  // Resolved pin levels
  output logic      [7:0] pin_lvl
);
  logic [7:0] eff_dir;
  logic [7:0] eff_val;
  // ---------------------------------------------------------------------------
  // Pin resolution
  // ---------------------------------------------------------------------------
  // open-drain line level.
  always_comb begin
    eff_dir = (direction_override_enable & direction_override_value) | (~direction_override_enable & pdir);
    eff_val = (port_value_override_enable & port_value_override_value) | (~port_value_override_enable & pout);
    pin_lvl = (eff_dir & eff_val) | ~eff_dir;
  end
endmodule

// >>> verification/pbo_top_tb.sv
// Self-checking testbench for the port B override logic.
`timescale 1ns/1ps
module pbo_top_tb;
  logic       clk, rstn, two_w, three_w, hold, shb, sdo, sta, ca_en, cb_en, ca, cb, ca_n, cb_n, t0s;
  logic       gie, ea, eb, ei, frst, f4, f5, fext, eia, e0, e2, qa, qb, qi, c;
  logic [7:0] pout, pdir, pullup_override_enable, pullup_override_value, direction_override_enable, direction_override_value, port_value_override_enable, port_value_override_value, dioe, diov, pca, pin_lvl;
  int         mismatches, check_count;

  pbo_top pbo_top_i (
    .CORE_CLK(clk), .RSTN(rstn), .SERIAL_TWO_WIRE_MODE(two_w), .SERIAL_THREE_WIRE_MODE(three_w),
    .CLOCK_STRETCH_HOLD(hold), .SHIFT_OUT_BIT(shb), .SERIAL_DATA_OUT(sdo), .START_DETECT_IRQ_EN(sta),
    .COMPARE_A_OUT_EN(ca_en), .COMPARE_B_OUT_EN(cb_en), .COMPARE_A_WAVE(ca), .COMPARE_B_WAVE(cb),
    .COMPARE_A_WAVE_N(ca_n), .COMPARE_B_WAVE_N(cb_n), .TIMER0_EXT_CLOCK_SELECTED(t0s),
    .PORT_OUT(pout), .PORT_DIR(pdir), .GLOBAL_IRQ_EN(gie), .GROUP_A_CHANGE_IRQ_EN(ea),
    .GROUP_B_CHANGE_IRQ_EN(eb), .EXTERNAL_IRQ_ZERO_EN(ei), .RESET_PIN_SELECT(frst),
    .PIN4_GPIO_ALLOWED(f4), .PIN5_GPIO_ALLOWED(f5), .EXTERNAL_CLOCK_SELECTED(fext),
    .PULLUP_OVERRIDE_ENABLE(pullup_override_enable), .PULLUP_OVERRIDE_VALUE(pullup_override_value), .DIRECTION_OVERRIDE_ENABLE(direction_override_enable),
    .DIRECTION_OVERRIDE_VALUE(direction_override_value), .PORT_VALUE_OVERRIDE_ENABLE(port_value_override_enable), .PORT_VALUE_OVERRIDE_VALUE(port_value_override_value),
    .INPUT_ENABLE_OVERRIDE_ENABLE(dioe), .INPUT_ENABLE_OVERRIDE_VALUE(diov),
    .PIN_CHANGE_ACTIVE(pca), .EXTERNAL_IRQ_ZERO_ACTIVE(eia)
  );

  pbo_pin_model pbo_pin_model_i (
    .direction_override_enable(direction_override_enable), .direction_override_value(direction_override_value), .port_value_override_enable(port_value_override_enable), .port_value_override_value(port_value_override_value), .pdir(pdir), .pout(pout), .pin_lvl(pin_lvl)
  );

  always #10 clk = ~clk;

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic tick;
    @(posedge clk);
    #2;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    clk = 0; rstn = 0; two_w = 0; three_w = 0; hold = 0; shb = 0; sdo = 0; sta = 0;
    ca_en = 0; cb_en = 0; ca = 0; cb = 0; ca_n = 1; cb_n = 1; t0s = 0; pout = 8'h00; pdir = 8'h00;
    gie = 0; ea = 0; eb = 0; ei = 0; frst = 1; f4 = 0; f5 = 0; fext = 1;
    mismatches = 0; check_count = 0;
    repeat (20) tick;
    rstn = 1;
    tick;
    #1;
    chk8(pullup_override_enable, 8'hb0);
    chk8(pullup_override_value & 8'hb0, 8'h80);
    chk8(direction_override_enable, 8'hb0);
    chk8(direction_override_value & 8'hb0, 8'h00);
    chk8(port_value_override_enable, 8'h00);
    chk8(dioe, 8'hb0);
    chk8(diov & dioe, 8'h10);
    frst = 0; f4 = 1; fext = 0;
    tick;
    #1;
    chk8(pullup_override_enable, 8'hb0);
    gie = 1; ea = 1; ca_en = 1; cb_en = 1;
    for (int i = 0; i < 64; i++) begin
      tick;
      two_w = 1;
      {pout[0], shb, hold, pout[2], pdir[0], pdir[2]} = i[5:0];
      #1;
      e0 = (~shb | ~pout[0]) & pdir[0];
      e2 = (hold | ~pout[2]) & pdir[2];
      chk8(pullup_override_enable & 8'h05, 8'h05);
      chk8(pullup_override_value & 8'h05, 8'h00);
      chk8(direction_override_enable & 8'h05, 8'h05);
      chk8({6'h00, direction_override_value[2], direction_override_value[0]}, {6'h00, e2, e0});
      chk8({6'h00, port_value_override_value[2], port_value_override_value[0]}, {6'h00, ~pdir[2], ~pdir[0]});
      chk8({6'h00, pin_lvl[2], pin_lvl[0]}, {6'h00, ~e2, ~e0});
    end
    tick;
    ca_en = 0; cb_en = 0; pdir = 8'h00; pout = 8'h00;
    #1;
    chk8(pca & 8'h0f, 8'h0a);
    tick;
    two_w = 0; three_w = 1;
    #1;
    chk8(pca & 8'h0f, 8'h08);
    ca_en = 1; cb_en = 1; gie = 0; ea = 0;
    for (int j = 0; j < 8; j++) begin
      tick;
      // data input pin kept as input.
      pdir[0] = 0;
      {three_w, ca, cb} = j[2:0];
      ca_n = ~ca; cb_n = ~cb; sdo = ~ca;
      #1;
      chk8(port_value_override_enable & 8'h0f, 8'h0f);
      chk8(port_value_override_value & 8'h0f, {4'h0, cb, cb_n, three_w ? sdo : ca, ca_n});
      chk8((direction_override_enable | pullup_override_enable) & 8'h0f, 8'h00);
    end
    three_w = 0;
    for (int k = 0; k < 64; k++) begin
      tick;
      {gie, ea, eb, ei, t0s, c} = k[5:0];
      ca_en = c; cb_en = c;
      #1;
      qa = gie & ea; qb = gie & eb; qi = gie & ei;
      chk8(pca, {1'b0, qb & ~(qi | t0s), 1'b0, 1'b0, {4{qa & ~c}}});
      chk8({7'h00, eia}, {7'h00, qi});
      chk8(dioe & 8'h4f, {1'b0, qb & ~t0s | qi, 2'b00, {4{qa & ~c}}});
      chk8(diov & 8'h4f, 8'h4f);
    end
    tick;
    {gie, ea, eb, ei, t0s, ca_en, cb_en} = 7'h00;
    sta = 1;
    #1;
    chk8(dioe & 8'h05, 8'h05);
    tick;
    sta = 0; rstn = 0; f5 = 1;
    repeat (3) tick;
    rstn = 1;
    tick;
    gie = 1; eb = 1;
    #1;
    chk8((pullup_override_enable | direction_override_enable) & 8'hf0, 8'h00);
    chk8(pca & 8'hf0, 8'hf0);
    chk8(diov & dioe & 8'h90, 8'h90);
    summarize;
  end

  initial begin
    #100000;
    mismatches++;
    summarize;
  end
endmodule
